// >>> pti_threshold_irq.sv
/*
  Two threshold-detect instances, the interrupt status flags, the first
  interrupt enable bank and the active-low interrupt pin, behind an
  Avalon-MM slave with waitrequest.
  Register map, one byte in bits 7:0 of each 32-bit word, byte address
  four times the index:
    0x00 status, write one to clear
    0x50 measurement pick, instance A in 2:0, instance B in 6:4
    0x51 hysteresis: channel selects, run length code, band code
    0x52 instance A high limit
    0x53 instance A low limit
    0x54 instance B high limit
    0x55 instance B low limit
    0x58 interrupt enable, same layout as status
  Assumes samples and event pulses come from logic on clk_i; the
  sequencer, FIFO and ambient cancellation live elsewhere.
*/
// Implementation choice: the Avalon-MM slave port.
// Notes on behaviour
// - channel-select bit picks optical channel one or two
// - need 1, 2, 4 or 8 consecutive out-of-limit samples
// - level band is plus/minus half the magnitude
// - upper byte scaled by 2048 ADC counts
// - upper limit zero disables upper comparison
// - lower byte scaled by 2048 ADC counts
// - lower limit zero disables lower comparison
// - qualified event sets instance status flag
// - almost-full enabled flag drives interrupt pin
// - disabled enable bit hides flag from pin
// - frame-ready enabled flag drives interrupt pin
// - data-ready enabled flag drives interrupt pin
// - ambient overflow enabled flag drives interrupt pin
// - measurement pick zero or seven disables instance
`timescale 1ns/1ps
`default_nettype none
`include "pti_regs.svh"

module pti_threshold_irq #(
  parameter int ADDR_W = 10
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sample stream from the sequencer
  input wire logic sample_valid_i,
  input wire pti_pkg::pti_pick_t sample_meas_i,
  input wire pti_pkg::pti_adc_t sample_ch1_i,
  input wire pti_pkg::pti_adc_t sample_ch2_i,
  // Event pulses from neighbouring blocks
  input wire logic fifo_almost_full_evt_i,
  input wire logic frame_ready_evt_i,
  input wire logic fifo_data_ready_evt_i,
  input wire logic ambient_cancel_overflow_evt_i,
  input wire logic exposure_overflow_evt_i,
  // Interrupt pin and event strobes
  output logic irq_out_n_o,
  output logic thr_a_event_flag_o,
  output logic thr_b_event_flag_o
);
  import pti_pkg::*;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  pti_byte_t status_reg;
  pti_byte_t status_next;
  pti_byte_t enable_reg;
  pti_byte_t hyst_reg;
  pti_byte_t pick_reg;
  pti_byte_t a_high_reg;
  pti_byte_t a_low_reg;
  pti_byte_t b_high_reg;
  pti_byte_t b_low_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_n_reg;
  logic [1:0] thr_hit;
  logic [1:0] thr_evt_reg;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic req;
  logic take;
  logic wr_take;
  logic [7:0] idx;
  pti_byte_t wbyte;
  pti_byte_t rbyte;

  assign req = avs_read_i | avs_write_i;
  assign take = req & ~wait_reg;
  assign wr_take = take & avs_write_i & avs_byteenable_i[0];
  assign idx = avs_address_i[9:2];
  assign wbyte = avs_writedata_i[7:0];

  always_comb begin
    unique case (idx)
      `PTI_IDX_IRQ_STATUS: rbyte = status_reg;
      `PTI_IDX_MEAS_PICK: rbyte = pick_reg;
      `PTI_IDX_HYST_CFG: rbyte = hyst_reg;
      `PTI_IDX_A_HIGH: rbyte = a_high_reg;
      `PTI_IDX_A_LOW: rbyte = a_low_reg;
      `PTI_IDX_B_HIGH: rbyte = b_high_reg;
      `PTI_IDX_B_LOW: rbyte = b_low_reg;
      `PTI_IDX_IRQ_ENABLE: rbyte = enable_reg;
      default: rbyte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  // One wait state: read data are latched while waitrequest is still high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wait_reg <= 1'b1;
    end else if (take) begin
      wait_reg <= 1'b1;
    end else if (req) begin
      wait_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && wait_reg) begin
      rdata_reg <= {24'h00_0000, rbyte};
    end
  end

  // --------------------------------------------------------------------
  // Write strobes, one per register
  // --------------------------------------------------------------------
  logic wr_status;
  logic wr_pick;
  logic wr_hyst;
  logic wr_enable;
  logic wr_a_high;
  logic wr_a_low;
  logic wr_b_high;
  logic wr_b_low;

  assign wr_status = wr_take && (idx == `PTI_IDX_IRQ_STATUS);
  assign wr_pick = wr_take && (idx == `PTI_IDX_MEAS_PICK);
  assign wr_hyst = wr_take && (idx == `PTI_IDX_HYST_CFG);
  assign wr_enable = wr_take && (idx == `PTI_IDX_IRQ_ENABLE);
  assign wr_a_high = wr_take && (idx == `PTI_IDX_A_HIGH);
  assign wr_a_low = wr_take && (idx == `PTI_IDX_A_LOW);
  assign wr_b_high = wr_take && (idx == `PTI_IDX_B_HIGH);
  assign wr_b_low = wr_take && (idx == `PTI_IDX_B_LOW);

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Reserved bits are masked on the way in, so they always read zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pick_reg <= `PTI_RST_CFG;
    end else if (wr_pick) begin
      pick_reg <= wbyte & `PTI_MASK_PICK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hyst_reg <= `PTI_RST_CFG;
    end else if (wr_hyst) begin
      hyst_reg <= wbyte & `PTI_MASK_HYST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enable_reg <= `PTI_RST_CFG;
    end else if (wr_enable) begin
      enable_reg <= wbyte & `PTI_MASK_ENABLE;
    end
  end

  // Limits are not checked for order; a crossed pair is simply compared
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      a_high_reg <= `PTI_RST_HIGH;
    end else if (wr_a_high) begin
      a_high_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      a_low_reg <= `PTI_RST_LOW;
    end else if (wr_a_low) begin
      a_low_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      b_high_reg <= `PTI_RST_HIGH;
    end else if (wr_b_high) begin
      b_high_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      b_low_reg <= `PTI_RST_LOW;
    end else if (wr_b_low) begin
      b_low_reg <= wbyte;
    end
  end

  // --------------------------------------------------------------------
  // Shared hysteresis settings
  // --------------------------------------------------------------------
  logic [1:0] time_code;
  logic [2:0] level_code;
  logic [3:0] run_needed;
  pti_wide_t half_band;

  assign time_code = hyst_reg[`PTI_HYST_TIME_LSB +: 2];
  assign level_code = hyst_reg[`PTI_HYST_LEVEL_LSB +: 3];

  // Code zero: a single out-of-limit sample is enough
  always_comb begin
    unique case (time_code)
      2'h0: run_needed = `PTI_RUN_CODE0;
      2'h1: run_needed = `PTI_RUN_CODE1;
      2'h2: run_needed = `PTI_RUN_CODE2;
      2'h3: run_needed = `PTI_RUN_CODE3;
    endcase
  end

  always_comb begin
    half_band = 21'h00_0000;
    if (level_code != 3'h0) begin
      half_band = 21'h00_0001 << (level_code - 3'h1);
    end
  end

  // --------------------------------------------------------------------
  // Threshold instances
  // --------------------------------------------------------------------
  pti_byte_t high_byte [2];
  pti_byte_t low_byte [2];
  pti_pick_t pick [2];
  logic chan_sel [2];

  assign high_byte[0] = a_high_reg;
  assign high_byte[1] = b_high_reg;
  assign low_byte[0] = a_low_reg;
  assign low_byte[1] = b_low_reg;
  assign pick[0] = pick_reg[`PTI_PICK_A_LSB +: 3];
  assign pick[1] = pick_reg[`PTI_PICK_B_LSB +: 3];
  assign chan_sel[0] = hyst_reg[`PTI_HYST_A_CHAN_BIT];
  assign chan_sel[1] = hyst_reg[`PTI_HYST_B_CHAN_BIT];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_thr
      logic active;
      logic mine;
      pti_wide_t value;
      pti_wide_t high_lim;
      pti_wide_t low_lim;
      logic over;
      logic under;
      logic outside;
      logic [3:0] run_reg;

      // Reserved code behaves like code zero
      assign active = (pick[g] != 3'h0) && (pick[g] != `PTI_PICK_RESERVED);
      assign mine = sample_valid_i && active && (sample_meas_i == pick[g]);
      assign value = {1'b0, chan_sel[g] ? sample_ch2_i : sample_ch1_i};
      assign high_lim = {2'b00, high_byte[g], 11'h000} + half_band;
      assign low_lim = {2'b00, low_byte[g], 11'h000} - half_band;
      assign over = (high_byte[g] != 8'h00) && (value > high_lim);
      assign under = (low_byte[g] != 8'h00) && (value < low_lim);
      assign outside = over | under;
      assign thr_hit[g] = mine && outside && ((run_reg + 4'h1) >= run_needed);

      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          run_reg <= 4'h0;
        end else if (!active) begin
          run_reg <= 4'h0;
        end else if (mine) begin
          if (!outside) begin
            run_reg <= 4'h0;
          end else if (thr_hit[g]) begin
            run_reg <= 4'h0;
          end else begin
            run_reg <= run_reg + 4'h1;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  pti_byte_t set_vec;
  pti_byte_t clr_vec;

  always_comb begin
    set_vec = 8'h00;
    set_vec[`PTI_ST_A_FULL] = fifo_almost_full_evt_i;
    set_vec[`PTI_ST_FRAME_RDY] = frame_ready_evt_i;
    set_vec[`PTI_ST_DATA_RDY] = fifo_data_ready_evt_i;
    set_vec[`PTI_ST_AMBIENT_CANCEL_OVERFLOW_FLAG] = ambient_cancel_overflow_evt_i;
    set_vec[`PTI_ST_EXP_OVF] = exposure_overflow_evt_i;
    set_vec[`PTI_ST_THR_B] = thr_hit[1];
    set_vec[`PTI_ST_THR_A] = thr_hit[0];
  end

  assign clr_vec = wr_status ? wbyte : 8'h00;
  // Set beats a clear landing in the same cycle
  assign status_next = (status_reg & ~clr_vec) | set_vec;

  // Flags still set while their enable bit is zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      thr_evt_reg <= 2'b00;
    end else begin
      thr_evt_reg <= thr_hit;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt pin
  // --------------------------------------------------------------------
  pti_byte_t armed;

  assign armed = status_reg & enable_reg;

  // Follows the stored flags, so the pin lags a flag by one cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~|armed;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_out_n_o = irq_n_reg;
  assign thr_a_event_flag_o = thr_evt_reg[0];
  assign thr_b_event_flag_o = thr_evt_reg[1];

endmodule

`default_nettype wire

// >>> pti_regs.svh
/*
  Register indices, field positions, reset values and limit scaling of the
  threshold-detect and interrupt-enable block.
  Assumes a 32-bit Avalon-MM bus: byte address is four times the index.
*/
`ifndef PTI_REGS_SVH
`define PTI_REGS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define PTI_IDX_IRQ_STATUS 8'h00
`define PTI_IDX_MEAS_PICK 8'h50
`define PTI_IDX_HYST_CFG 8'h51
`define PTI_IDX_A_HIGH 8'h52
`define PTI_IDX_A_LOW 8'h53
`define PTI_IDX_B_HIGH 8'h54
`define PTI_IDX_B_LOW 8'h55
`define PTI_IDX_IRQ_ENABLE 8'h58

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTI_HYST_B_CHAN_BIT 7
`define PTI_HYST_A_CHAN_BIT 6
`define PTI_HYST_TIME_LSB 3
`define PTI_HYST_LEVEL_LSB 0
`define PTI_PICK_B_LSB 4
`define PTI_PICK_A_LSB 0
`define PTI_ST_A_FULL 7
`define PTI_ST_FRAME_RDY 6
`define PTI_ST_DATA_RDY 5
`define PTI_ST_AMBIENT_CANCEL_OVERFLOW_FLAG 4
`define PTI_ST_EXP_OVF 3
`define PTI_ST_THR_B 2
`define PTI_ST_THR_A 1

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define PTI_RST_HIGH 8'hFF
`define PTI_RST_LOW 8'h00
`define PTI_RST_CFG 8'h00
`define PTI_MASK_ENABLE 8'hFE
`define PTI_MASK_HYST 8'hDF
`define PTI_MASK_PICK 8'h77

// ----------------------------------------------------------------------
// Limit scaling: one limit unit is 2048 ADC counts
// ----------------------------------------------------------------------
`define PTI_LIMIT_SHIFT 11
`define PTI_PICK_RESERVED 3'h7

// ----------------------------------------------------------------------
// Consecutive samples needed per run length code
// ----------------------------------------------------------------------
`define PTI_RUN_CODE0 4'h1
`define PTI_RUN_CODE1 4'h2
`define PTI_RUN_CODE2 4'h4
`define PTI_RUN_CODE3 4'h8

`endif

// >>> pti_pkg.sv
/*
  Types shared by the threshold-detect and interrupt-enable block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package pti_pkg;
  typedef logic [7:0] pti_byte_t;
  typedef logic [19:0] pti_adc_t;
  typedef logic [20:0] pti_wide_t;
  typedef logic [2:0] pti_pick_t;
endpackage

`default_nettype wire

// >>> pti_threshold_irq_checker.sv
/* Port checker for pti_threshold_irq, bound after the module.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module pti_threshold_irq_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sample_valid_i,
  input wire logic fifo_almost_full_evt_i,
  input wire logic frame_ready_evt_i,
  input wire logic fifo_data_ready_evt_i,
  input wire logic ambient_cancel_overflow_evt_i,
  input wire logic exposure_overflow_evt_i,
  input wire logic irq_out_n_o,
  input wire logic thr_a_event_flag_o,
  input wire logic thr_b_event_flag_o
);
  // ----
  // Helpers
  // ----
  logic any_evt, thr_any, wr_done;
  assign any_evt = fifo_almost_full_evt_i | frame_ready_evt_i | fifo_data_ready_evt_i |
    ambient_cancel_overflow_evt_i | exposure_overflow_evt_i;
  assign thr_any = thr_a_event_flag_o | thr_b_event_flag_o;
  assign wr_done = avs_write_i & ~avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ask;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_grant;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  // ----
  // Assertions
  // ----
  chk_wait_one: assert property (s_ask |=> s_grant)
    else $error("bus answer not one wait state");
  chk_wait_cause: assert property ($fell(avs_waitrequest_o) |->
    $past(avs_read_i) || $past(avs_write_i))
    else $error("bus answer without request");
  chk_read_upper: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_reset_out: assert property ($rose(reset_n_i) |->
    avs_waitrequest_o && irq_out_n_o && !thr_any)
    else $error("outputs wrong after reset");
  chk_flag_a_cause: assert property (thr_a_event_flag_o |-> $past(sample_valid_i))
    else $error("first event without sample");
  chk_flag_b_cause: assert property (thr_b_event_flag_o |-> $past(sample_valid_i))
    else $error("second event without sample");
  // Pin falls only from a fresh event, flag or enable write
  chk_irq_fall: assert property ($fell(irq_out_n_o) |->
    $past(any_evt, 2) || $past(thr_any) || $past(wr_done, 2))
    else $error("pin fell without cause");
  chk_irq_rise: assert property ($rose(irq_out_n_o) |-> $past(wr_done, 2))
    else $error("pin rose without write");
endmodule
bind pti_threshold_irq pti_threshold_irq_checker chk_i (
  .clk_i, .reset_n_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .sample_valid_i, .fifo_almost_full_evt_i, .frame_ready_evt_i, .fifo_data_ready_evt_i,
  .ambient_cancel_overflow_evt_i, .exposure_overflow_evt_i, .irq_out_n_o,
  .thr_a_event_flag_o, .thr_b_event_flag_o
);
`default_nettype wire

// >>> tb_pti_threshold_irq.sv
/* Bench for pti_threshold_irq: bus, samples, events and pin.
   Assumes the port checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module tb_pti_threshold_irq;
  import pti_pkg::*;
  typedef struct packed {pti_pick_t m; pti_adc_t a; pti_adc_t b; logic [1:0] f;} pti_row_t;
  logic clk_i = 1'b0, reset_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic sample_valid_i = 1'b0, avs_waitrequest_o, irq_out_n_o;
  logic thr_a_event_flag_o, thr_b_event_flag_o;
  logic [9:0] avs_address_i = 10'h000;
  logic [3:0] avs_byteenable_i = 4'hF, be_v = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [7:3] evt = 5'h00;
  logic [1:0] fl = 2'h0, acc = 2'h0;
  pti_pick_t sample_meas_i = 3'h0;
  pti_adc_t sample_ch1_i = 20'h0, sample_ch2_i = 20'h0;
  int err_total = 0, n_tests = 0;
  // Edges of both bands: A 4092..6148 on ch1, B low 2044 on ch2
  pti_row_t rows [8] = '{'{3'h1, 20'h01804, 20'h01388, 2'h0}, '{3'h1, 20'h01805, 20'h0, 2'h1},
    '{3'h1, 20'h00FFC, 20'h0, 2'h0}, '{3'h1, 20'h00FFB, 20'h0, 2'h1},
    '{3'h2, 20'h0, 20'h007FC, 2'h0}, '{3'h2, 20'h01805, 20'h007FB, 2'h2},
    '{3'h2, 20'h003E8, 20'hFFFFF, 2'h0}, '{3'h3, 20'h01805, 20'h0, 2'h0}};
  pti_threshold_irq pti_threshold_irq_i (
    .clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sample_valid_i, .sample_meas_i,
    .sample_ch1_i, .sample_ch2_i, .fifo_almost_full_evt_i(evt[7]), .frame_ready_evt_i(evt[6]),
    .fifo_data_ready_evt_i(evt[5]), .ambient_cancel_overflow_evt_i(evt[4]),
    .exposure_overflow_evt_i(evt[3]), .irq_out_n_o, .thr_a_event_flag_o, .thr_b_event_flag_o
  );
  always #20 clk_i = ~clk_i;
  // ----
  // Tasks
  // ----
  task automatic wr(input pti_byte_t i, input pti_byte_t d);
    @(posedge clk_i);
    avs_address_i <= {i, 2'h0};
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be_v;
    avs_write_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask
  task automatic chk(input pti_byte_t g, input pti_byte_t e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input pti_byte_t i, input pti_byte_t e);
    @(posedge clk_i);
    avs_address_i <= {i, 2'h0};
    avs_read_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    chk(avs_readdata_o[7:0], e);
    avs_read_i <= 1'b0;
  endtask
  task automatic pin(input logic e);
    repeat (2) @(posedge clk_i);
    #1 chk({7'h0, irq_out_n_o}, {7'h0, e});
  endtask
  task automatic smp(input pti_pick_t m, input pti_adc_t a, input pti_adc_t b);
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    sample_meas_i <= m;
    sample_ch1_i <= a;
    sample_ch2_i <= b;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    #1 fl = {thr_b_event_flag_o, thr_a_event_flag_o};
    acc = acc | fl;
  endtask
  task automatic ev(input logic [7:3] v);
    @(posedge clk_i);
    evt <= v;
    @(posedge clk_i);
    evt <= 5'h00;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wr(8'h50, 8'h21);
    wr(8'h51, 8'h83);
    wr(8'h52, 8'h03);
    wr(8'h53, 8'h02);
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h01);
    foreach (rows[i]) begin
      smp(rows[i].m, rows[i].a, rows[i].b);
      chk({6'h0, fl}, {6'h0, rows[i].f});
    end
    pin(1'b1);
    rc(8'h00, 8'h06);
    wr(8'h58, 8'h06);
    pin(1'b0);
    wr(8'h00, 8'h02);
    pin(1'b0);
    wr(8'h00, 8'h04);
    pin(1'b1);
    $display("done: limits and pin");
    wr(8'h50, 8'h01);
    wr(8'h52, 8'h01);
    wr(8'h53, 8'h00);
    // Break each run once, then slip in a foreign measurement
    for (int c = 1; c < 4; c++) begin
      wr(8'h51, pti_byte_t'(c << 3));
      acc = 2'h0;
      repeat ((1 << c) - 1) smp(3'h1, 20'h00801, 20'h0);
      smp(3'h1, 20'h00064, 20'h0);
      repeat ((1 << c) - 1) smp(3'h1, 20'h00801, 20'h0);
      smp(3'h2, 20'h00801, 20'h0);
      chk({6'h0, acc}, 8'h00);
      smp(3'h1, 20'h00801, 20'h0);
      chk({6'h0, fl}, 8'h01);
    end
    // Widest band with a zero low limit: the low side must stay off
    wr(8'h51, 8'h07);
    smp(3'h1, 20'h00064, 20'h0);
    chk({6'h0, fl}, 8'h00);
    smp(3'h1, 20'h00840, 20'h0);
    chk({6'h0, fl}, 8'h00);
    smp(3'h1, 20'h00841, 20'h0);
    chk({6'h0, fl}, 8'h01);
    for (int p = 0; p < 8; p += 7) begin
      wr(8'h50, pti_byte_t'(p * 8'h11));
      smp(pti_pick_t'(p), 20'h00841, 20'h0);
      chk({6'h0, fl}, 8'h00);
    end
    $display("done: runs and picks");
    for (int k = 3; k < 8; k++) begin
      wr(8'h00, 8'hFF);
      wr(8'h58, pti_byte_t'(1 << k));
      ev(5'h1F ^ 5'(1 << (k - 3)));
      pin(1'b1);
      ev(5'(1 << (k - 3)));
      pin(1'b0);
      rc(8'h00, 8'hF8);
      wr(8'h00, pti_byte_t'(1 << k));
      pin(1'b1);
    end
    $display("done: events");
    wr(8'h58, 8'hFF);
    rc(8'h58, 8'hFE);
    wr(8'h51, 8'hFF);
    rc(8'h51, 8'hDF);
    wr(8'h50, 8'hFF);
    rc(8'h50, 8'h77);
    be_v = 4'hE;
    wr(8'h52, 8'h5A);
    be_v = 4'hF;
    rc(8'h52, 8'h01);
    wr(8'h20, 8'hAA);
    rc(8'h20, 8'h00);
    $display("done: registers");
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rc(8'h52, 8'hFF);
    rc(8'h54, 8'hFF);
    rc(8'h53, 8'h00);
    rc(8'h55, 8'h00);
    rc(8'h58, 8'h00);
    rc(8'h51, 8'h00);
    rc(8'h00, 8'h00);
    pin(1'b1);
    $display("done: reset");
    final_report();
  end
endmodule
`default_nettype wire
